/* File: rtl/pcr_pkg.sv */
package pcr_pkg;

    // ------------------------------------------------------------
    // register indices (printed offsets, not multiples of four)
    // ------------------------------------------------------------
    localparam logic [7:0] PCR_IDX_PIN_CFG = 8'h12;    // pin_function_and_drive_cfg
    localparam logic [7:0] PCR_IDX_TALLY = 8'h14;      // conversion_tally
    localparam logic [7:0] PCR_IDX_H1_MAG = 8'h15;     // harmonic1_magnitude
    localparam logic [7:0] PCR_IDX_H1_PH = 8'h16;      // harmonic1_phase
    localparam logic [7:0] PCR_IDX_H2_MAG = 8'h17;     // harmonic2_magnitude
    localparam logic [7:0] PCR_IDX_H2_PH = 8'h18;      // harmonic2_phase
    localparam logic [7:0] PCR_IDX_H3_MAG = 8'h19;     // harmonic3_magnitude
    localparam logic [7:0] PCR_IDX_H3_PH = 8'h1A;      // harmonic3_phase
    localparam logic [7:0] PCR_IDX_PIN_IN = 8'h1B;     // pin input levels, read only

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int PCR_NUM_PINS = 6;                   // multipurpose pins
    localparam int PCR_FNC_LSB = 0;                    // function select [5:0]
    localparam int PCR_DRV_LSB = 8;                    // driver enables [13:8]
    localparam logic [15:0] PCR_PIN_CFG_RESET = 16'h201F;
    localparam logic [15:0] PCR_PIN_CFG_WMASK = 16'h3F3F;
    localparam logic [15:0] PCR_COEF_RESET = 16'h0000;
    localparam logic [7:0] PCR_TALLY_RESET = 8'h00;
    localparam int PCR_MAG_WIDE_W = 11;                // first and second magnitude
    localparam int PCR_MAG_NARROW_W = 8;               // third magnitude
    localparam int PCR_PH_W = 12;                      // all phases
    localparam int PCR_TALLY_W = 8;

    // pin numbers with a dedicated function
    localparam int PCR_PIN_BUSY = 0;
    localparam int PCR_PIN_CONVERT = 1;
    localparam int PCR_PIN_ANGLE = 3;
    localparam int PCR_PIN_BOOT = 5;

    // pin drive as two signals each
    typedef struct packed {
        logic [5:0] out;      // level driven
        logic [5:0] oe_n;     // low while driving
    } pcr_pin_drive_t;

    // sequencer events and indicators
    typedef struct packed {
        logic seq_done;       // sequence ended, completed or cut short
        logic seq_abort;      // sequence cut short by a new start
        logic busy;           // busy indication
        logic angle_calc;     // angle-calculation indicator
        logic boot_load;      // boot-load indicator
    } pcr_core_t;

endpackage

/* File: rtl/pcr_regs.sv */
// Function
// - fnc bit one: gpio, zero: dedicated
// - driver on only when enable bit set
// - gpio with enable zero is input
// - pin config resets to 201F
// - pin five dedicated: boot-load output
// - pin three dedicated: angle-calc output
// - pin one dedicated: convert-start input only
// - pin zero dedicated: busy output
// - tally advances on completed sequence
// - aborted sequence does not advance tally
// - tally wraps FF to 00
// - first magnitude 11 bits, resets zero
// - second magnitude 11 bits read-write
// - third magnitude 8 bits read-write
// - three phases 12 bits read-write
// - second, third coefficients reset zero
//
// Our own choice: the APB interface to the registers.
module pcr_regs
    import pcr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pcr_core_t core,
    output logic convert_start_input,
    output logic [5:0] gpio_in,
    input wire logic [5:0] pin_in,
    output pcr_pin_drive_t pin_drive,
    output logic [15:0] pin_cfg,
    output logic [10:0] h1_mag,
    output logic [11:0] h1_ph,
    output logic [10:0] h2_mag,
    output logic [11:0] h2_ph,
    output logic [7:0] h3_mag,
    output logic [11:0] h3_ph
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [15:0] pin_cfg_q;                            // fnc and driver bits
    logic [PCR_TALLY_W-1:0] tally_q;                   // completed sequences
    logic [PCR_MAG_WIDE_W-1:0] h1_mag_q;
    logic [PCR_PH_W-1:0] h1_ph_q;
    logic [PCR_MAG_WIDE_W-1:0] h2_mag_q;
    logic [PCR_PH_W-1:0] h2_ph_q;
    logic [PCR_MAG_NARROW_W-1:0] h3_mag_q;
    logic [PCR_PH_W-1:0] h3_ph_q;
    logic [31:0] prdata_q;                             // registered read data
    logic pslverr_q;
    logic pready_q;                                    // one wait state

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [9:0] idx;                                   // word index
    logic access;                                      // access phase, first cycle
    logic wr;
    logic rd;
    logic mapped;
    logic [15:0] wdata;                                // low half, strobes applied in merge
    logic [15:0] lane_mask;

    assign idx = paddr[11:2];
    // answer lands in the second access cycle so data can be registered
    assign access = psel && penable && !pready_q;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata = pwdata[15:0];

    // ------------------------------------------------------------
    // per-register write strobes
    // ------------------------------------------------------------
    logic wr_pin_cfg;                                  // pin config write
    logic wr_h1_mag;                                   // first magnitude write
    logic wr_h1_ph;                                    // first phase write
    logic wr_h2_mag;                                   // second magnitude write
    logic wr_h2_ph;                                    // second phase write
    logic wr_h3_mag;                                   // third magnitude write
    logic wr_h3_ph;                                    // third phase write

    // one decode per register keeps the update processes short
    assign wr_pin_cfg = wr && (idx == {2'b00, PCR_IDX_PIN_CFG});
    assign wr_h1_mag = wr && (idx == {2'b00, PCR_IDX_H1_MAG});
    assign wr_h1_ph = wr && (idx == {2'b00, PCR_IDX_H1_PH});
    assign wr_h2_mag = wr && (idx == {2'b00, PCR_IDX_H2_MAG});
    assign wr_h2_ph = wr && (idx == {2'b00, PCR_IDX_H2_PH});
    // upper byte is read-only, so only lane zero can change it
    assign wr_h3_mag = wr && (idx == {2'b00, PCR_IDX_H3_MAG}) && pstrb[0];
    assign wr_h3_ph = wr && (idx == {2'b00, PCR_IDX_H3_PH});
    // tally and pin-input writes decode to nothing: dropped quietly

    // address decode against the index table
    always_comb begin
        unique case (idx)
            {2'b00, PCR_IDX_PIN_CFG},
            {2'b00, PCR_IDX_TALLY},
            {2'b00, PCR_IDX_H1_MAG},
            {2'b00, PCR_IDX_H1_PH},
            {2'b00, PCR_IDX_H2_MAG},
            {2'b00, PCR_IDX_H2_PH},
            {2'b00, PCR_IDX_H3_MAG},
            {2'b00, PCR_IDX_H3_PH},
            {2'b00, PCR_IDX_PIN_IN}: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;                         // unmapped: error answer
            end
        endcase
    end

    // masked write helper: keep old bits where lane is off
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // ------------------------------------------------------------
    // lane-merged write values
    // ------------------------------------------------------------
    // a call result cannot be sliced, so merge into full words first
    logic [15:0] pin_cfg_m;                            // pin config after lanes
    logic [15:0] h1_mag_m;                             // first magnitude after lanes
    logic [15:0] h1_ph_m;                              // first phase after lanes
    logic [15:0] h2_mag_m;                             // second magnitude after lanes
    logic [15:0] h2_ph_m;                              // second phase after lanes
    logic [15:0] h3_ph_m;                              // third phase after lanes

    // narrow fields are zero-extended so reserved bits stay zero
    assign pin_cfg_m = merge(pin_cfg_q, wdata, lane_mask);
    assign h1_mag_m = merge({5'h00, h1_mag_q}, wdata, lane_mask);
    assign h1_ph_m = merge({4'h0, h1_ph_q}, wdata, lane_mask);
    assign h2_mag_m = merge({5'h00, h2_mag_q}, wdata, lane_mask);
    assign h2_ph_m = merge({4'h0, h2_ph_q}, wdata, lane_mask);
    assign h3_ph_m = merge({4'h0, h3_ph_q}, wdata, lane_mask);

    // ------------------------------------------------------------
    // pin configuration register
    // ------------------------------------------------------------
    // power-on default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_cfg_q <= PCR_PIN_CFG_RESET;
        end else if (wr_pin_cfg) begin
            // reserved bits kept zero
            // mask after the merge, so a stale lane cannot set them
            pin_cfg_q <= pin_cfg_m & PCR_PIN_CFG_WMASK;
        end
    end

    // ------------------------------------------------------------
    // harmonic coefficients
    // ------------------------------------------------------------
    // first harmonic, 11-bit magnitude, zero reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h1_mag_q <= PCR_COEF_RESET[PCR_MAG_WIDE_W-1:0];
            h1_ph_q <= PCR_COEF_RESET[PCR_PH_W-1:0];
        end else if (wr) begin
            // upper five bits of the word are dropped here
            if (wr_h1_mag) begin
                h1_mag_q <= h1_mag_m[PCR_MAG_WIDE_W-1:0];
            end
            if (wr_h1_ph) begin
                h1_ph_q <= h1_ph_m[PCR_PH_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h2_mag_q <= PCR_COEF_RESET[PCR_MAG_WIDE_W-1:0];
            h2_ph_q <= PCR_COEF_RESET[PCR_PH_W-1:0];
        end else if (wr) begin
            // upper five bits of the word are dropped here
            if (wr_h2_mag) begin
                h2_mag_q <= h2_mag_m[PCR_MAG_WIDE_W-1:0];
            end
            if (wr_h2_ph) begin
                h2_ph_q <= h2_ph_m[PCR_PH_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h3_mag_q <= PCR_COEF_RESET[PCR_MAG_NARROW_W-1:0];
            h3_ph_q <= PCR_COEF_RESET[PCR_PH_W-1:0];
        end else if (wr) begin
            // whole field sits in lane zero, no merge needed
            if (wr_h3_mag) begin
                h3_mag_q <= wdata[PCR_MAG_NARROW_W-1:0];
            end
            if (wr_h3_ph) begin
                h3_ph_q <= h3_ph_m[PCR_PH_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // conversion tally
    // ------------------------------------------------------------
    // read only; host writes are dropped without error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tally_q <= PCR_TALLY_RESET;
        end else if (core.seq_done && !core.seq_abort) begin
            // advance, natural wrap to zero
            // eight-bit sum, so FF plus one lands on 00
            tally_q <= tally_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // read path and answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            // answer follows the first access cycle by one edge
            pready_q <= access;                        // one wait state
            pslverr_q <= access && !mapped;
            if (rd) begin
                // upper bits and reserved bits read zero
                unique case (idx)
                    // pin config, reserved bits already zero
                    {2'b00, PCR_IDX_PIN_CFG}: begin
                        prdata_q <= {16'h0000, pin_cfg_q};
                    end
                    // tally in the low byte
                    {2'b00, PCR_IDX_TALLY}: begin
                        prdata_q <= {24'h0, tally_q};
                    end
                    // first magnitude, 11 bits
                    {2'b00, PCR_IDX_H1_MAG}: begin
                        prdata_q <= {21'h0, h1_mag_q};
                    end
                    // first phase, 12 bits
                    {2'b00, PCR_IDX_H1_PH}: begin
                        prdata_q <= {20'h0, h1_ph_q};
                    end
                    // second magnitude, 11 bits
                    {2'b00, PCR_IDX_H2_MAG}: begin
                        prdata_q <= {21'h0, h2_mag_q};
                    end
                    // second phase, 12 bits
                    {2'b00, PCR_IDX_H2_PH}: begin
                        prdata_q <= {20'h0, h2_ph_q};
                    end
                    // third magnitude, 8 bits
                    {2'b00, PCR_IDX_H3_MAG}: begin
                        prdata_q <= {24'h0, h3_mag_q};
                    end
                    // third phase, 12 bits
                    {2'b00, PCR_IDX_H3_PH}: begin
                        prdata_q <= {20'h0, h3_ph_q};
                    end
                    // raw pad levels, whatever the pin function
                    {2'b00, PCR_IDX_PIN_IN}: begin
                        prdata_q <= {26'h0, pin_in};
                    end
                    // unmapped: zero data with the error answer
                    default: begin
                        prdata_q <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // pin muxing
    // ------------------------------------------------------------
    logic [5:0] fnc_gpio;                              // one: gpio use
    logic [5:0] drv_en;                                // driver enables
    logic [5:0] ded_val;                               // dedicated output levels
    logic [5:0] ded_out;                               // dedicated function is an output
    logic [5:0] pin_out_q;
    logic [5:0] pin_oe_n_q;

    assign fnc_gpio = pin_cfg_q[PCR_FNC_LSB +: PCR_NUM_PINS];
    assign drv_en = pin_cfg_q[PCR_DRV_LSB +: PCR_NUM_PINS];

    // dedicated function per pin
    always_comb begin
        ded_val = 6'h00;
        ded_out = 6'h00;
        ded_val[PCR_PIN_BUSY] = core.busy;
        ded_out[PCR_PIN_BUSY] = 1'b1;
        ded_out[PCR_PIN_CONVERT] = 1'b0;
        ded_val[PCR_PIN_ANGLE] = core.angle_calc;
        ded_out[PCR_PIN_ANGLE] = 1'b1;
        ded_val[PCR_PIN_BOOT] = core.boot_load;
        ded_out[PCR_PIN_BOOT] = 1'b1;
    end

    // registered pad drive, glitch free on config changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_q <= 6'h00;
            pin_oe_n_q <= 6'h3F;
        end else begin
            for (int i = 0; i < PCR_NUM_PINS; i++) begin
                if (fnc_gpio[i]) begin
                    // drive only with enable set, else input
                    pin_oe_n_q[i] <= !drv_en[i];
                    pin_out_q[i] <= 1'b0;
                end else begin
                    // dedicated outputs also gated by enable
                    pin_oe_n_q[i] <= !(drv_en[i] && ded_out[i]);
                    pin_out_q[i] <= ded_val[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pad and datapath outputs
    // ------------------------------------------------------------
    // levels straight from flip-flops, no logic after them
    assign pin_drive.out = pin_out_q;
    assign pin_drive.oe_n = pin_oe_n_q;

    // convert start seen only in dedicated use
    assign convert_start_input = !fnc_gpio[PCR_PIN_CONVERT] && pin_in[PCR_PIN_CONVERT];
    // dedicated pins read as zero on the gpio side
    assign gpio_in = pin_in & fnc_gpio;

    // coefficients feed the correction datapath outside this group

    assign pin_cfg = pin_cfg_q;
    assign h1_mag = h1_mag_q;
    assign h1_ph = h1_ph_q;
    assign h2_mag = h2_mag_q;
    assign h2_ph = h2_ph_q;
    assign h3_mag = h3_mag_q;
    assign h3_ph = h3_ph_q;

endmodule

/* File: tb/pcr_seq_model.sv */
// -------------------------------------------
// conversion sequencer stand-in
// -------------------------------------------
module pcr_seq_model
    import pcr_pkg::*;
(
    input wire logic pclk,
    output pcr_core_t core
);
    timeunit 1ns;
    timeprecision 1ps;

    initial core = '0;

    // one-cycle done pulse, optionally cut short by a new start
    task finish(input logic cut);
        @(posedge pclk);
        core.seq_done <= 1'b1;
        core.seq_abort <= cut;
        @(posedge pclk);
        core.seq_done <= 1'b0;
        core.seq_abort <= 1'b0;
    endtask

    // indicator levels: busy, angle, boot
    task levels(input logic [2:0] l);
        core.busy <= l[2];
        core.angle_calc <= l[1];
        core.boot_load <= l[0];
    endtask
endmodule

/* File: tb/pcr_regs_asserts.sv */
// -------------------------------------------
// port checker for the register group
// -------------------------------------------
module pcr_regs_chk
    import pcr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire pcr_core_t core,
    input wire logic convert_start_input,
    input wire logic [5:0] gpio_in,
    input wire logic [5:0] pin_in,
    input wire pcr_pin_drive_t pin_drive,
    input wire logic [15:0] pin_cfg,
    input wire logic [10:0] h1_mag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // exactly one wait state, then a single-cycle answer
    a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_err_pair: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_gpio_sense: assert property (gpio_in == (pin_in & pin_cfg[5:0])) else $error("gpio_in wrong");
    // pin outputs lag config by one edge, so past values are the cause
    a_drive_gate: assert property ((~pin_drive.oe_n & ~$past(pin_cfg[13:8])) == 6'h00) else $error("driver on");
    a_cfg_reserved: assert property (pin_cfg[15:14] == 2'b00 && pin_cfg[7:6] == 2'b00) else $error("rsv set");
    a_boot_pin: assert property ($past(presetn) && !$past(pin_cfg[5]) && $past(pin_cfg[13]) |->
        !pin_drive.oe_n[5] && pin_drive.out[5] == $past(core.boot_load)) else $error("boot pin wrong");
    a_angle_pin: assert property ($past(presetn) && !$past(pin_cfg[3]) && $past(pin_cfg[11]) |->
        !pin_drive.oe_n[3] && pin_drive.out[3] == $past(core.angle_calc)) else $error("angle pin wrong");
    a_busy_pin: assert property ($past(presetn) && !$past(pin_cfg[0]) && $past(pin_cfg[8]) |->
        !pin_drive.oe_n[0] && pin_drive.out[0] == $past(core.busy)) else $error("busy pin wrong");
    a_convert_quiet: assert property (!$past(pin_cfg[1]) |-> pin_drive.oe_n[1]) else $error("pin1 drives");
    a_convert_in: assert property (convert_start_input == (!pin_cfg[1] && pin_in[1])) else $error("cnv wrong");
    a_mag_hold: assert property (!(psel && penable && pwrite) |=> $stable(h1_mag)) else $error("mag moved");
endmodule

bind pcr_regs pcr_regs_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .core,
    .convert_start_input, .gpio_in, .pin_in, .pin_drive, .pin_cfg, .h1_mag);

/* File: tb/tb_pin_config_and_harmonic_cal_regs.sv */
module tb_pin_config_and_harmonic_cal_regs
    import pcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------
    // stimulus and observed signals
    // -------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [5:0] pin_in = 6'h2A; // fixed pad pattern
    logic [31:0] prdata, rd;
    logic pready, pslverr, conv, er;
    logic [5:0] gpio_in;
    pcr_pin_drive_t pin_drive;
    pcr_core_t core;
    int fails = 0, total_checks = 0;
    // register table: index, reset value, writable bits
    logic [7:0] idx [8] = '{PCR_IDX_PIN_CFG, PCR_IDX_TALLY, PCR_IDX_H1_MAG, PCR_IDX_H1_PH,
        PCR_IDX_H2_MAG, PCR_IDX_H2_PH, PCR_IDX_H3_MAG, PCR_IDX_H3_PH};
    logic [15:0] rst [8] = '{16'h201F, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] msk [8] = '{16'h3F3F, 16'h0000, 16'h07FF, 16'h0FFF, 16'h07FF, 16'h0FFF, 16'h00FF, 16'h0FFF};
    // pin cases: config and {oe_n, driven out, gpio_in, convert}
    logic [15:0] pcfg [3] = '{16'h0B00, 16'h003F, 16'h2000};
    logic [31:0] pexp [3] = '{32'h0006_C481, 32'h0007_E054, 32'h0003_F001};

    always #5 pclk = ~pclk;

    pcr_seq_model seq_u (.pclk(pclk), .core(core));

    pcr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core(core), .convert_start_input(conv), .gpio_in(gpio_in), .pin_in(pin_in), .pin_drive(pin_drive),
        .pin_cfg(), .h1_mag(), .h1_ph(), .h2_mag(), .h2_ph(), .h3_mag(), .h3_ph());

    // -------------------------------------------
    // checking and bus tasks
    // -------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready, data and error taken at the rising edge that samples them
    task xfer(input logic w, input logic [7:0] ix, input logic [15:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input logic [7:0] ix, input logic [31:0] exp);
        xfer(1'b0, ix, 16'h0000);
        chk(rd, exp);
    endtask

    task conclude;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // -------------------------------------------
    // test sequence
    // -------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then all ones to find writable bits
        for (int i = 0; i < 8; i++) begin
            rdc(idx[i], {16'h0000, rst[i]});
            xfer(1'b1, idx[i], 16'hFFFF);
            rdc(idx[i], {16'h0000, msk[i]});
        end
        // upper lane off must keep the upper byte
        pstrb <= 4'h1;
        xfer(1'b1, PCR_IDX_H1_PH, 16'h0055);
        pstrb <= 4'hF;
        rdc(PCR_IDX_H1_PH, 32'h0000_0F55);
        // completed sequences count, an aborted one does not
        repeat (3) seq_u.finish(1'b0);
        seq_u.finish(1'b1);
        rdc(PCR_IDX_TALLY, 32'h0000_0003);
        repeat (253) seq_u.finish(1'b0);
        rdc(PCR_IDX_TALLY, 32'h0000_0000);
        // unmapped index answers with an error
        xfer(1'b0, 8'h1C, 16'h0000);
        chk({31'h0, er}, 32'h0000_0001);
        rdc(PCR_IDX_PIN_IN, 32'h0000_002A);
        // pin function and driver cases with all indicators high
        seq_u.levels(3'b111);
        for (int j = 0; j < 3; j++) begin
            xfer(1'b1, PCR_IDX_PIN_CFG, pcfg[j]);
            @(negedge pclk);
            chk({13'h0, pin_drive.oe_n, pin_drive.out & ~pin_drive.oe_n, gpio_in, conv}, pexp[j]);
        end
        // host-scaled magnitude: 1000 times the gain is written as 607
        xfer(1'b1, PCR_IDX_H2_MAG, 16'h025F);
        rdc(PCR_IDX_H2_MAG, 32'h0000_025F);
        conclude();
    end

    // hang guard, well beyond the roughly 660 cycles the run needs
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        conclude();
    end
endmodule
